// ==== rtl/cpurf_regs.vh ====
// register-file constants: field positions, reset values, operation codes
`ifndef CPURF_REGS_VH
`define CPURF_REGS_VH
// condition_flags bit positions
`define CPURF_CCR_I 7
`define CPURF_CCR_U1 6
`define CPURF_CCR_H 5
`define CPURF_CCR_U0 4
`define CPURF_CCR_N 3
`define CPURF_CCR_Z 2
`define CPURF_CCR_V 1
`define CPURF_CCR_C 0
// reset vector address and stack pointer register index
`define CPURF_PC_RESET_VEC 16'h0000
`define CPURF_SP_INDEX 3'h7
// write size codes for general register port
`define CPURF_SZ_WORD 2'h0
`define CPURF_SZ_HIGH 2'h1
`define CPURF_SZ_LOW 2'h2
// flag-update operation codes
`define CPURF_OP_NONE 4'h0
`define CPURF_OP_ADDB 4'h1
`define CPURF_OP_SUBB 4'h2
`define CPURF_OP_ADDW 4'h3
`define CPURF_OP_SUBW 4'h4
`define CPURF_OP_LOGB 4'h5
`define CPURF_OP_LOGW 4'h6
`define CPURF_OP_SHFB 4'h7
`define CPURF_OP_BITC 4'h8
// flags-instruction codes
`define CPURF_FI_NONE 3'h0
`define CPURF_FI_LOAD 3'h1
`define CPURF_FI_AND 3'h2
`define CPURF_FI_OR 3'h3
`define CPURF_FI_XOR 3'h4
// branch condition codes
`define CPURF_BR_ALWAYS 4'h0
`define CPURF_BR_NEVER 4'h1
`define CPURF_BR_HI 4'h2
`define CPURF_BR_LS 4'h3
`define CPURF_BR_CC 4'h4
`define CPURF_BR_CS 4'h5
`define CPURF_BR_NE 4'h6
`define CPURF_BR_EQ 4'h7
`define CPURF_BR_VC 4'h8
`define CPURF_BR_VS 4'h9
`define CPURF_BR_PL 4'ha
`define CPURF_BR_MI 4'hb
`define CPURF_BR_GE 4'hc
`define CPURF_BR_LT 4'hd
`define CPURF_BR_GT 4'he
`define CPURF_BR_LE 4'hf
`endif

// ==== rtl/cpurf_flag_calc.v ====
// flag computation from an operation's operands and result
`timescale 1ns/1ps
module cpurf_flag_calc (
    input wire [3:0] op_i,           // flag-update operation code
    input wire [15:0] opa_i,         // first operand
    input wire [15:0] opb_i,         // second operand
    input wire [15:0] res_i,         // result
    input wire carry_in_i,           // shifted-out bit or bit accumulator value
    input wire [7:0] flags_i,        // current flags
    output reg [7:0] flags_o         // updated flags
);
`include "cpurf_regs.vh"
    // ===========================================================
    // flag derivation
    reg [4:0] nib_sum;
    reg [12:0] w12_sum;
    reg [8:0] b_sum;
    reg [16:0] w_sum;
    reg sub_b;
    reg wide;
    always @*
    begin
        flags_o = flags_i;
        sub_b = (op_i == `CPURF_OP_SUBB) || (op_i == `CPURF_OP_SUBW);
        wide = (op_i == `CPURF_OP_ADDW) || (op_i == `CPURF_OP_SUBW) || (op_i == `CPURF_OP_LOGW);
        // borrow expressed as inverted carry of a + ~b + 1
        nib_sum = {1'b0, opa_i[3:0]} + {1'b0, (sub_b ? ~opb_i[3:0] : opb_i[3:0])} + {4'h0, sub_b};
        w12_sum = {1'b0, opa_i[11:0]} + {1'b0, (sub_b ? ~opb_i[11:0] : opb_i[11:0])} + {12'h000, sub_b};
        b_sum = {1'b0, opa_i[7:0]} + {1'b0, (sub_b ? ~opb_i[7:0] : opb_i[7:0])} + {8'h00, sub_b};
        w_sum = {1'b0, opa_i} + {1'b0, (sub_b ? ~opb_i : opb_i)} + {16'h0000, sub_b};
        case (op_i)
            `CPURF_OP_ADDB, `CPURF_OP_SUBB:
            begin
                flags_o[`CPURF_CCR_H] = nib_sum[4] ^ sub_b;
                flags_o[`CPURF_CCR_C] = b_sum[8] ^ sub_b;
                flags_o[`CPURF_CCR_V] = (opa_i[7] ^ res_i[7]) & ~(opa_i[7] ^ opb_i[7] ^ sub_b);
            end
            `CPURF_OP_ADDW, `CPURF_OP_SUBW:
            begin
                flags_o[`CPURF_CCR_H] = w12_sum[12] ^ sub_b;
                flags_o[`CPURF_CCR_C] = w_sum[16] ^ sub_b;
                flags_o[`CPURF_CCR_V] = (opa_i[15] ^ res_i[15]) & ~(opa_i[15] ^ opb_i[15] ^ sub_b);
            end
            `CPURF_OP_LOGB, `CPURF_OP_LOGW:
                flags_o[`CPURF_CCR_V] = 1'b0;
            `CPURF_OP_SHFB:
                flags_o[`CPURF_CCR_C] = carry_in_i;
            `CPURF_OP_BITC:
                flags_o[`CPURF_CCR_C] = carry_in_i;
            default:
                flags_o = flags_i;
        endcase
        // sign and zero follow the result width
        if (op_i != `CPURF_OP_NONE && op_i != `CPURF_OP_BITC)
        begin
            flags_o[`CPURF_CCR_N] = wide ? res_i[15] : res_i[7];
            flags_o[`CPURF_CCR_Z] = wide ? (res_i == 16'h0000) : (res_i[7:0] == 8'h00);
        end
    end
endmodule // cpurf_flag_calc

// ==== rtl/cpurf_branch_eval.v ====
// conditional branch evaluation from the arithmetic flags
`timescale 1ns/1ps
module cpurf_branch_eval (
    input wire [3:0] cond_i,         // branch condition code
    input wire [7:0] flags_i,        // condition flags
    output reg taken_o               // branch taken
);
`include "cpurf_regs.vh"
    // ===========================================================
    // condition decode, only n z v c are consulted
    wire n = flags_i[`CPURF_CCR_N];
    wire z = flags_i[`CPURF_CCR_Z];
    wire v = flags_i[`CPURF_CCR_V];
    wire c = flags_i[`CPURF_CCR_C];
    always @*
    begin
        case (cond_i)
            `CPURF_BR_ALWAYS: taken_o = 1'b1;
            `CPURF_BR_NEVER: taken_o = 1'b0;
            `CPURF_BR_HI: taken_o = ~(c | z);
            `CPURF_BR_LS: taken_o = c | z;
            `CPURF_BR_CC: taken_o = ~c;
            `CPURF_BR_CS: taken_o = c;
            `CPURF_BR_NE: taken_o = ~z;
            `CPURF_BR_EQ: taken_o = z;
            `CPURF_BR_VC: taken_o = ~v;
            `CPURF_BR_VS: taken_o = v;
            `CPURF_BR_PL: taken_o = ~n;
            `CPURF_BR_MI: taken_o = n;
            `CPURF_BR_GE: taken_o = ~(n ^ v);
            `CPURF_BR_LT: taken_o = n ^ v;
            `CPURF_BR_GT: taken_o = ~(z | (n ^ v));
            `CPURF_BR_LE: taken_o = z | (n ^ v);
            default: taken_o = 1'b0;
        endcase
    end
endmodule // cpurf_branch_eval

// ==== rtl/cpurf_top.v ====
// cpu general registers, program counter and condition flags
`timescale 1ns/1ps
// Overview of operation
// - sixteen byte registers pair into eight words
// - data access by word, upper or lower byte
// - address reads always use the whole word
// - register seven serves as stack pointer
// - 16-bit program counter, lowest bit reads zero
// - eight-bit flags register, fixed bit layout
// - mask bit set blocks maskable interrupts
// - exception entry forces mask bit to one
// - two user bits are plain storage
// - byte arithmetic half-carry from bit three
// - word arithmetic half-carry from bit eleven
// - negative flag takes result sign bit
// - zero flag marks all-zero result
// - overflow flag marks signed overflow
// - carry from add, borrow, shifted bit
// - carry is the bit-operation accumulator
// - branches decide from n, z, v, c
// - flags loadable, storable, and/or/xor immediate
// - reset loads vector zero, sets mask only
// - bit operands select positions zero to seven
// - decimal adjust uses half-carry on digits
// - word ops limited; address add/sub word-only
module cpurf_top #(
    parameter NREG = 8                // number of word registers
) (
    input wire sys_clk_i,             // cpu clock
    input wire rst_b_i,               // asynchronous reset, active low
    input wire clk_en_i,              // clock enable, freezes state when low
    // general register read ports
    input wire [2:0] rd_a_idx_i,      // read port a word index
    input wire [1:0] rd_a_size_i,     // read port a size code
    output wire [15:0] rd_a_data_o,   // read port a data
    input wire [2:0] rd_b_idx_i,      // read port b word index
    input wire [1:0] rd_b_size_i,     // read port b size code
    output wire [15:0] rd_b_data_o,   // read port b data
    input wire [2:0] addr_idx_i,      // address source word index
    output wire [15:0] addr_data_o,   // address source, always full word
    output wire [15:0] stack_pointer_o, // current stack top
    // general register write port
    input wire wr_en_i,               // write strobe
    input wire [2:0] wr_idx_i,        // write word index
    input wire [1:0] wr_size_i,       // write size code
    input wire [15:0] wr_data_i,      // write data, bytes in low bits
    // stack pointer adjust
    input wire sp_wr_i,               // stack pointer update strobe
    input wire [15:0] sp_data_i,      // new stack pointer value
    // program counter
    input wire pc_wr_i,               // program counter load strobe
    input wire [15:0] pc_data_i,      // program counter load value
    input wire pc_inc_i,              // advance by one word
    input wire vec_load_i,            // reset vector fetch done strobe
    input wire [15:0] vec_data_i,     // vector contents
    output wire [15:0] program_counter_o, // fetch address, bit 0 zero
    output wire [15:0] vec_addr_o,    // reset vector address
    // flags
    input wire [3:0] flag_op_i,       // flag-update operation
    input wire [15:0] flag_opa_i,     // first operand
    input wire [15:0] flag_opb_i,     // second operand
    input wire [15:0] flag_res_i,     // operation result
    input wire flag_cin_i,            // shifted-out bit or accumulator value
    input wire [2:0] flags_instr_i,   // flags-instruction code
    input wire [7:0] flags_imm_i,     // flags-instruction operand
    input wire exc_entry_i,           // exception handling begins
    output wire [7:0] condition_flags_o, // condition_flags register
    output wire int_blocked_o,        // maskable interrupts blocked
    // branch
    input wire [3:0] br_cond_i,       // branch condition code
    output wire br_taken_o,           // branch condition met
    // bit operand select
    input wire [2:0] bit_pos_i,       // bit position in byte
    input wire bit_src_hi_i,          // source is upper byte
    input wire [2:0] bit_idx_i,       // register holding the bit
    output wire bit_val_o,            // selected bit value
    // decimal adjust
    input wire [7:0] dadj_in_i,       // byte holding two digits
    input wire dadj_sub_i,            // adjust after subtract
    output wire [7:0] dadj_out_o      // adjusted byte
);
`include "cpurf_regs.vh"

    // ===========================================================
    // reset release synchroniser
    reg rst_s1_q;
    reg rst_s2_q;
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // ===========================================================
    // shared decode helpers
    function [15:0] cpurf_rd_sel;
        input [15:0] word;
        input [1:0] size;
        begin
            case (size)
                `CPURF_SZ_HIGH: cpurf_rd_sel = {8'h00, word[15:8]};
                `CPURF_SZ_LOW: cpurf_rd_sel = {8'h00, word[7:0]};
                default: cpurf_rd_sel = word;
            endcase
        end
    endfunction

    // ===========================================================
    // general registers, held as upper and lower byte halves
    // no reset: contents are undefined until software writes them
    reg [7:0] gen_hi_q [0:NREG-1];
    reg [7:0] gen_lo_q [0:NREG-1];
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi = gi + 1)
        begin : g_reg
            wire sel = wr_en_i && (wr_idx_i == gi);
            wire is_sp = (gi == `CPURF_SP_INDEX);
            always @(posedge sys_clk_i)
            begin
                if (clk_en_i)
                begin
                    // byte halves write independently
                    if (sel && wr_size_i == `CPURF_SZ_WORD)
                    begin
                        gen_hi_q[gi] <= wr_data_i[15:8];
                        gen_lo_q[gi] <= wr_data_i[7:0];
                    end
                    else if (sel && wr_size_i == `CPURF_SZ_HIGH)
                        gen_hi_q[gi] <= wr_data_i[7:0];
                    else if (sel && wr_size_i == `CPURF_SZ_LOW)
                        gen_lo_q[gi] <= wr_data_i[7:0];
                    else if (is_sp && sp_wr_i)
                    begin
                        // implicit stack adjust yields to an explicit write
                        gen_hi_q[gi] <= sp_data_i[15:8];
                        gen_lo_q[gi] <= sp_data_i[7:0];
                    end
                end
            end
        end
    endgenerate

    // read ports
    wire [15:0] word_a = {gen_hi_q[rd_a_idx_i], gen_lo_q[rd_a_idx_i]};
    wire [15:0] word_b = {gen_hi_q[rd_b_idx_i], gen_lo_q[rd_b_idx_i]};
    assign rd_a_data_o = cpurf_rd_sel(word_a, rd_a_size_i);
    assign rd_b_data_o = cpurf_rd_sel(word_b, rd_b_size_i);
    // addresses ignore the size code entirely
    assign addr_data_o = {gen_hi_q[addr_idx_i], gen_lo_q[addr_idx_i]};
    assign stack_pointer_o = {gen_hi_q[`CPURF_SP_INDEX], gen_lo_q[`CPURF_SP_INDEX]};

    // ===========================================================
    // program counter; bit 0 never stored, so odd loads fall back a byte
    reg [14:0] pc_q;
    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            pc_q <= 15'h0000;
        else if (clk_en_i)
        begin
            if (vec_load_i)
                pc_q <= vec_data_i[15:1];
            else if (pc_wr_i)
                pc_q <= pc_data_i[15:1];
            else if (pc_inc_i)
                pc_q <= pc_q + 15'h0001;
        end
    end
    assign program_counter_o = {pc_q, 1'b0};
    assign vec_addr_o = `CPURF_PC_RESET_VEC;

    // ===========================================================
    // condition flags
    reg [7:0] ccr_q;
    wire [7:0] flags_calc;
    reg [7:0] ccr_d;

    cpurf_flag_calc u_flag_calc (
        .op_i(flag_op_i),
        .opa_i(flag_opa_i),
        .opb_i(flag_opb_i),
        .res_i(flag_res_i),
        .carry_in_i(flag_cin_i),
        .flags_i(ccr_q),
        .flags_o(flags_calc)
    );

    // flags instruction wins over arithmetic update; exception entry forces mask
    always @*
    begin
        case (flags_instr_i)
            `CPURF_FI_LOAD: ccr_d = flags_imm_i;
            `CPURF_FI_AND: ccr_d = ccr_q & flags_imm_i;
            `CPURF_FI_OR: ccr_d = ccr_q | flags_imm_i;
            `CPURF_FI_XOR: ccr_d = ccr_q ^ flags_imm_i;
            default: ccr_d = flags_calc;                    // user bits pass through
        endcase
        if (exc_entry_i)
            ccr_d[`CPURF_CCR_I] = 1'b1;
    end

    // one driver; only the mask bit is reset, others hold
    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            ccr_q[`CPURF_CCR_I] <= 1'b1;
        else if (clk_en_i)
            ccr_q <= ccr_d;
    end
    assign condition_flags_o = ccr_q;
    assign int_blocked_o = ccr_q[`CPURF_CCR_I];

    // ===========================================================
    // branch evaluation
    cpurf_branch_eval u_branch_eval (
        .cond_i(br_cond_i),
        .flags_i(ccr_q),
        .taken_o(br_taken_o)
    );

    // ===========================================================
    // single-bit operand select within a byte
    wire [7:0] bit_byte = bit_src_hi_i ? gen_hi_q[bit_idx_i] : gen_lo_q[bit_idx_i];
    assign bit_val_o = bit_byte[bit_pos_i];

    // ===========================================================
    // decimal adjust on two packed digits using half-carry and carry
    reg [7:0] dadj_corr;
    always @*
    begin
        dadj_corr = 8'h00;
        if (ccr_q[`CPURF_CCR_H] || (!dadj_sub_i && dadj_in_i[3:0] > 4'h9))
            dadj_corr[3:0] = 4'h6;
        if (ccr_q[`CPURF_CCR_C] || (!dadj_sub_i && dadj_in_i > 8'h99))
            dadj_corr[7:4] = 4'h6;
    end
    // subtract form only corrects on the recorded flags
    assign dadj_out_o = dadj_sub_i ? (dadj_in_i - dadj_corr) : (dadj_in_i + dadj_corr);

endmodule // cpurf_top

// ==== tb/cpurf_vec_model.sv ====
// far-side model: memory word behind the reset vector fetch
`timescale 1ns/1ps
module cpurf_vec_model #(
    parameter [15:0] VEC = 16'h0135 // arbitrary contents, odd to probe bit 0
) (
    input wire sys_clk_i, // cpu clock
    input wire rst_b_i, // reset, active low
    input wire [15:0] addr_i, // vector address from the core
    output reg [15:0] data_o, // vector contents
    output reg load_o // fetch done strobe
);
    // =====================================================
    // vector fetch after reset
    // wrong address or idle bus shows the inverse
    initial
    begin
        load_o = 1'b0;
        data_o = ~VEC;
    end
    always @(posedge rst_b_i)
    begin
        repeat (3) @(negedge sys_clk_i);
        data_o <= (addr_i == 16'h0000) ? VEC : ~VEC;
        load_o <= 1'b1;
        @(negedge sys_clk_i);
        load_o <= 1'b0;
        data_o <= ~VEC;
    end
endmodule // cpurf_vec_model

// ==== tb/cpurf_chk_asserts.sv ====
// concurrent checks on the register file ports
`timescale 1ns/1ps
module cpurf_chk (
    input wire sys_clk_i, // clock
    input wire rst_b_i, // reset
    input wire clk_en_i, // enable
    input wire wr_en_i, // write
    input wire [2:0] wr_idx_i, // index
    input wire [1:0] wr_size_i, // size
    input wire [15:0] wr_data_i, // data
    input wire [2:0] addr_idx_i, // addr index
    input wire [15:0] addr_data_o, // addr word
    input wire [15:0] stack_pointer_o, // stack top
    input wire pc_wr_i, // pc load
    input wire pc_inc_i, // pc step
    input wire vec_load_i, // vector load
    input wire [15:0] program_counter_o, // pc
    input wire [15:0] vec_addr_o, // vector addr
    input wire exc_entry_i, // exception
    input wire [2:0] flags_instr_i, // flags instr
    input wire [7:0] flags_imm_i, // operand
    input wire [7:0] condition_flags_o, // flags
    input wire int_blocked_o // masked
);
    // =====================================================
    // wait out the reset copy
    reg [1:0] rs_q;
    wire ok = (rs_q == 2'h3);
    always @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
            rs_q <= 2'h0;
        else if (rs_q != 2'h3)
            rs_q <= rs_q + 2'h1;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // =====================================================
    // properties
    sequence s_load;
        ok && clk_en_i && flags_instr_i == 3'h1 && !exc_entry_i;
    endsequence
    sequence s_step;
        ok && clk_en_i && pc_inc_i && !pc_wr_i && !vec_load_i;
    endsequence
    property p_pc_even; program_counter_o[0] == 1'b0; endproperty
    property p_vec_addr; vec_addr_o == 16'h0000; endproperty
    property p_mask_out; int_blocked_o == condition_flags_o[7]; endproperty
    property p_exc; ok && clk_en_i && exc_entry_i |=> condition_flags_o[7]; endproperty
    property p_pc_inc; s_step |=> program_counter_o == $past(program_counter_o) + 16'h0002; endproperty
    property p_sp_wr;
        ok && clk_en_i && wr_en_i && wr_idx_i == 3'h7 && wr_size_i == 2'h0 |=> stack_pointer_o == $past(wr_data_i);
    endproperty
    property p_addr; addr_idx_i == 3'h7 |-> addr_data_o == stack_pointer_o; endproperty
    property p_freeze; ok && !clk_en_i |=> $stable(program_counter_o); endproperty
    property p_load; s_load |=> condition_flags_o == $past(flags_imm_i); endproperty
    property p_rst; $rose(rst_b_i) |-> condition_flags_o[7] && program_counter_o == 16'h0000; endproperty
    a_pc_even: assert property (p_pc_even) else $error("pc bit 0 set");
    a_vec_addr: assert property (p_vec_addr) else $error("vector address not zero");
    a_mask_out: assert property (p_mask_out) else $error("interrupt block differs from mask");
    a_exc: assert property (p_exc) else $error("mask not set on exception");
    a_pc_inc: assert property (p_pc_inc) else $error("pc step not two");
    a_sp_wr: assert property (p_sp_wr) else $error("stack top not written");
    a_addr: assert property (p_addr) else $error("address view not full word");
    a_freeze: assert property (p_freeze) else $error("pc moved while disabled");
    a_load: assert property (p_load) else $error("flags load wrong");
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // cpurf_chk
bind cpurf_top cpurf_chk u_chk (.*);

// ==== tb/cpu_register_file_and_condition_codes_tb.sv ====
// self-checking bench for the register file and flags
`timescale 1ns/1ps
module cpu_register_file_and_condition_codes_tb;
    localparam [15:0] VEC = 16'h0135;
    reg clk = 0, rst_b = 0, en = 1, wr = 0, spw = 0, pcw = 0, pci = 0, exc = 0, dsub = 0, bhi = 0, cin = 0;
    reg [2:0] ra = 0, ai = 0, wi = 0, fi = 0, bp = 0, bi = 0;
    reg [1:0] rs = 0, ws = 0;
    reg [15:0] wd = 0, spd = 0, pcd = 0, fa = 0, fb = 0, fr = 0, seed = 16'ha5b0;
    reg [3:0] fop = 0, bc = 0;
    reg [7:0] imm = 0, din = 0, m_f;
    reg [15:0] m_r [0:7];
    wire [15:0] rda, rdb, adr, sp, pc, va, vd;
    wire vl, bt, bv, ib;
    wire [7:0] fl, dout;
    integer mismatches = 0, checks = 0, i, cyc = 0;
    // =====================================================
    // stimulus sources
    initial forever #2 clk = ~clk;
    cpurf_vec_model #(.VEC(VEC)) u_vec (.sys_clk_i(clk), .rst_b_i(rst_b), .addr_i(va), .data_o(vd), .load_o(vl));
    cpurf_top dut (.sys_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en), .rd_a_idx_i(ra), .rd_a_size_i(rs),
        .rd_a_data_o(rda), .rd_b_idx_i(ra), .rd_b_size_i(rs), .rd_b_data_o(rdb), .addr_idx_i(ai),
        .addr_data_o(adr), .stack_pointer_o(sp), .wr_en_i(wr), .wr_idx_i(wi), .wr_size_i(ws), .wr_data_i(wd),
        .sp_wr_i(spw), .sp_data_i(spd), .pc_wr_i(pcw), .pc_data_i(pcd), .pc_inc_i(pci), .vec_load_i(vl),
        .vec_data_i(vd), .program_counter_o(pc), .vec_addr_o(va), .flag_op_i(fop), .flag_opa_i(fa),
        .flag_opb_i(fb), .flag_res_i(fr), .flag_cin_i(cin), .flags_instr_i(fi), .flags_imm_i(imm),
        .exc_entry_i(exc), .condition_flags_o(fl), .int_blocked_o(ib), .br_cond_i(bc), .br_taken_o(bt),
        .bit_pos_i(bp), .bit_src_hi_i(bhi), .bit_idx_i(bi), .bit_val_o(bv), .dadj_in_i(din),
        .dadj_sub_i(dsub), .dadj_out_o(dout));
    // =====================================================
    // report helpers
    task wrap_up;
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk_w(input [47:0] nm, input [15:0] e, input [15:0] g);
    begin
        checks = checks + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
        end
    end
    endtask
    task chk_f(input [47:0] nm, input [7:0] e, input [7:0] g);
        chk_w(nm, {8'h00, e}, {8'h00, g});
    endtask
    // hang guard, run needs under 2000 cycles
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    // =====================================================
    // reference model pieces
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [7:0] f_ar(input [7:0] f, input sub, input w, input [15:0] a, input [15:0] b, input [15:0] r);
        integer m, h, s;
    begin
        m = w ? 65535 : 255;
        h = w ? 4095 : 15;
        s = w ? 32768 : 128;
        f_ar = {f[7:6], sub ? (a & h) < (b & h) : (a & h) + (b & h) > h, f[4], (r & s) != 0, r == 0,
            ((sub ? a ^ b : ~(a ^ b)) & (a ^ r) & s) != 0, sub ? a < b : a + b > m};
    end
    endfunction
    // odd codes are the complement of the even code below them
    function br(input [3:0] c, input [7:0] f);
        reg t;
    begin
        case (c[3:1])
            3'h0: t = 1'b1;
            3'h1: t = !(f[0] | f[2]);
            3'h2: t = !f[0];
            3'h3: t = !f[2];
            3'h4: t = !f[1];
            3'h5: t = !f[3];
            3'h6: t = !(f[3] ^ f[1]);
            default: t = !(f[2] | (f[3] ^ f[1]));
        endcase
        br = t ^ c[0];
    end
    endfunction
    // =====================================================
    // bus tasks; wreg, fins and fopt also update the model, rchk only checks
    task wreg(input [2:0] x, input [1:0] s, input [15:0] d);
    begin
        @(negedge clk);
        {wr, wi, ws, wd} <= {1'b1, x, s, d};
        @(negedge clk);
        wr <= 1'b0;
        m_r[x] = s == 0 ? d : s == 1 ? {d[7:0], m_r[x][7:0]} : {m_r[x][15:8], d[7:0]};
    end
    endtask
    task rchk(input [2:0] x);
        integer s;
    begin
        for (s = 0; s < 3; s = s + 1)
        begin
            @(negedge clk);
            {ra, ai, rs} <= {x, x, s[1:0]};
            #1;
            chk_w("rd_a", s == 0 ? m_r[x] : s == 1 ? m_r[x][15:8] : m_r[x][7:0], rda);
            chk_w("rd_b", s == 0 ? m_r[x] : s == 1 ? m_r[x][15:8] : m_r[x][7:0], rdb);
        end
        chk_w("addr", m_r[x], adr);
    end
    endtask
    task fins(input [2:0] c, input [7:0] v, input x);
    begin
        @(negedge clk);
        {fi, imm, exc} <= {c, v, x};
        @(negedge clk);
        {fi, exc} <= 4'h0;
        m_f = c == 1 ? v : c == 2 ? m_f & v : c == 3 ? m_f | v : c == 4 ? m_f ^ v : m_f;
        m_f[7] = m_f[7] | x;
        chk_f("flags", m_f, fl);
        chk_f("ib", {7'h0, m_f[7]}, {7'h0, ib});
    end
    endtask
    task fopt(input [3:0] o, input [15:0] a0, input [15:0] b0, input c);
        reg [15:0] a, b, r;
    begin
        a = (o == 3 || o == 4) ? a0 : a0 & 16'h00ff;
        b = (o == 3 || o == 4) ? b0 : b0 & 16'h00ff;
        r = o == 5 ? a & b : (o == 2 || o == 4) ? a - b : a + b;
        r = (o == 3 || o == 4) ? r : r & 16'h00ff;
        @(negedge clk);
        {fop, fa, fb, fr, cin} <= {o, a, b, r, c};
        @(negedge clk);
        fop <= 4'h0;
        if (o < 5)
            m_f = f_ar(m_f, o[0] == 1'b0, o > 2, a, b, r);
        else if (o == 5)
            m_f = {m_f[7:4], r[7], r[7:0] == 0, 1'b0, m_f[0]};
        if (o < 6)
            chk_f("flags", m_f, fl);
        else
            chk_f("carry", {7'h0, c}, {7'h0, fl[0]});
    end
    endtask
    // =====================================================
    // main sequence
    initial
    begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (8) @(negedge clk);
        chk_w("pc", VEC & 16'hfffe, pc);
        chk_f("mask", 8'h01, {7'h0, fl[7]});
        chk_w("vaddr", 16'h0000, va);
        // every word, then one byte half, read all three ways
        for (i = 0; i < 8; i = i + 1)
        begin
            seed = lfsr(seed);
            wreg(i[2:0], 2'h0, seed);
            seed = lfsr(seed);
            wreg(i[2:0], i[0] ? 2'h2 : 2'h1, seed);
            rchk(i[2:0]);
        end
        chk_w("sp", m_r[7], sp);
        seed = lfsr(seed);
        @(negedge clk);
        {spw, spd} <= {1'b1, seed};
        @(negedge clk);
        spw <= 1'b0;
        chk_w("sp", seed, sp);
        // odd load, then one step held back by the enable
        @(negedge clk);
        {pcw, pcd} <= {1'b1, 16'h3fff};
        @(negedge clk);
        {pcw, pci, en} <= 3'b010;
        @(negedge clk);
        en <= 1'b1;
        @(negedge clk);
        pci <= 1'b0;
        chk_w("pc", 16'h4000, pc);
        fins(3'h1, 8'h5a, 1'b0);
        fins(3'h2, 8'hf3, 1'b0);
        fins(3'h3, 8'h04, 1'b0);
        fins(3'h4, 8'hff, 1'b0);
        fins(3'h1, 8'h00, 1'b1);
        fopt(4'h1, 16'h000f, 16'h0001, 1'b0);
        fopt(4'h1, 16'h007f, 16'h0081, 1'b0);
        fopt(4'h2, 16'h0080, 16'h0001, 1'b0);
        fopt(4'h3, 16'h7fff, 16'h0001, 1'b0);
        fopt(4'h4, 16'h0000, 16'h0800, 1'b0);
        for (i = 0; i < 24; i = i + 1)
        begin
            seed = lfsr(seed);
            fopt(4'h1 + i % 5, seed, lfsr(seed), 1'b0);
        end
        fopt(4'h7, seed, 16'h0000, seed[0]);
        fopt(4'h8, seed, 16'h0000, 1'b1);
        for (i = 0; i < 64; i = i + 1)
        begin
            if (i % 16 == 0)
            begin
                seed = lfsr(seed);
                fins(3'h1, seed[7:0], 1'b0);
            end
            @(negedge clk);
            bc <= i[3:0];
            #1;
            chk_f("branch", {7'h0, br(i[3:0], m_f)}, {7'h0, bt});
        end
        for (i = 0; i < 16; i = i + 1)
        begin
            @(negedge clk);
            {bp, bhi, bi} <= {i[2:0], i[3], 3'h3};
            #1;
            chk_f("bit", {7'h0, m_r[3][i % 16]}, {7'h0, bv});
        end
        fins(3'h1, 8'h00, 1'b0);
        for (i = 0; i < 3; i = i + 1)
        begin
            @(negedge clk);
            {din, dsub} <= {i == 0 ? 8'h0a : 8'h45, i == 2};
            #1;
            chk_f("dadj", i == 0 ? 8'h10 : 8'h45, dout);
        end
        wrap_up;
    end
endmodule // cpu_register_file_and_condition_codes_tb
